/* File: inc/auxseq_defines.svh */
`ifndef AUXSEQ_DEFINES_SVH
`define AUXSEQ_DEFINES_SVH

`define AUXSEQ_ADDR_STEP9     12'h264
`define AUXSEQ_STEP9_INDEX    8'h99
`define AUXSEQ_STEP9_RESET    16'h0009
`define AUXSEQ_EN_BIT         15
`define AUXSEQ_GAIN_HI        14
`define AUXSEQ_GAIN_LO        13
`define AUXSEQ_NEG_BIT        4
`define AUXSEQ_POS_HI         3
`define AUXSEQ_POS_LO         0
`define AUXSEQ_WR_MASK        16'he01f
`define AUXSEQ_POS_FIRST_INT  4'h8

`endif

/* File: inc/auxseq_pkg.sv */
package auxseq_pkg;

    typedef enum logic [1:0] {
        AUXSEQ_GAIN_1,
        AUXSEQ_GAIN_2,
        AUXSEQ_GAIN_4
    } auxseq_gain_t;

    typedef enum logic [1:0] {
        AUXSEQ_NEG_GROUND,
        AUXSEQ_NEG_EXT7,
        AUXSEQ_NEG_AUTO
    } auxseq_neg_t;

    typedef enum logic [2:0] {
        AUXSEQ_SRC_EXTERNAL,
        AUXSEQ_SRC_TEMP,
        AUXSEQ_SRC_SHORT,
        AUXSEQ_SRC_TEST_DAC,
        AUXSEQ_SRC_SUPPLY
    } auxseq_src_t;

    typedef struct packed {
        logic         step_active_flag;
        auxseq_gain_t gain;
        auxseq_neg_t  neg;
        auxseq_src_t  src;
        logic [3:0]   pos_code;
    } auxseq_step_cfg_t;

endpackage : auxseq_pkg

/* File: core/auxseq_step9.sv */
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "auxseq_defines.svh"
// Summary of operation
// - bit 15 enables the ninth sequencer step when 1 and disables it when 0.
// - bits 14:13 give gain 1 for 00b, gain 2 for 01b, gain 4 for 10b or 11b.
// - bit 4 picks ground (0) or external input seven (1) as negative input.
// - positive codes 0000b to 0111b pick external inputs zero to seven.
// - codes 1000b up pick temp sensor, short, test dac, then supply monitors.
// - for internal sources the negative select bit is ignored.
// - register at index 99h resets to 0009h: off, gain 1, auto negative, short.
module auxseq_step9
    import auxseq_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    input  wire logic [3:0]       pstrb,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    output auxseq_step_cfg_t      step_cfg
);

    logic [15:0] ninth_step_setup;
    logic [15:0] next_ninth_step_setup;
    logic [31:0] next_prdata;
    logic        hit;
    logic        access;
    logic        wr_hit;
    logic        rd_setup;

    // constants held as words so fields can be sliced from them
    localparam logic [15:0] wr_mask  = `AUXSEQ_WR_MASK;
    localparam logic [15:0] rst_word = `AUXSEQ_STEP9_RESET;
    localparam logic [3:0]  rst_pos  = rst_word[`AUXSEQ_POS_HI:`AUXSEQ_POS_LO];

    assign hit      = (paddr == `AUXSEQ_ADDR_STEP9);
    assign access   = psel && penable;
    assign wr_hit   = access && pwrite && hit;
    assign rd_setup = psel && !penable && !pwrite;
    // zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = access && !hit;

    always_comb begin
        next_ninth_step_setup = ninth_step_setup;
        if (wr_hit) begin
            if (pstrb[0]) begin
                // reserved low bits dropped by the mask
                next_ninth_step_setup[7:0] =
                    pwdata[7:0] & wr_mask[7:0];
            end
            if (pstrb[1]) begin
                next_ninth_step_setup[15:8] =
                    pwdata[15:8] & wr_mask[15:8];
            end
        end
    end

    always_comb begin
        next_prdata = prdata;
        if (rd_setup) begin
            next_prdata = hit ? {16'h0000, ninth_step_setup} : 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ninth_step_setup <= rst_word;
            prdata           <= 32'h0000_0000;
        end else begin
            ninth_step_setup <= next_ninth_step_setup;
            prdata           <= next_prdata;
        end
    end

    // decode of the stored fields toward the sequencer
    auxseq_step_cfg_t next_step_cfg;
    logic [3:0]       pos;

    assign pos = ninth_step_setup[`AUXSEQ_POS_HI:`AUXSEQ_POS_LO];

    always_comb begin
        next_step_cfg.step_active_flag =
            ninth_step_setup[`AUXSEQ_EN_BIT];
        case (ninth_step_setup[`AUXSEQ_GAIN_HI:`AUXSEQ_GAIN_LO])
            2'h0:    next_step_cfg.gain = AUXSEQ_GAIN_1;
            2'h1:    next_step_cfg.gain = AUXSEQ_GAIN_2;
            default: next_step_cfg.gain = AUXSEQ_GAIN_4;
        endcase
        next_step_cfg.pos_code = pos;
        if (pos < `AUXSEQ_POS_FIRST_INT) begin
            next_step_cfg.src = AUXSEQ_SRC_EXTERNAL;
            next_step_cfg.neg = ninth_step_setup[`AUXSEQ_NEG_BIT]
                              ? AUXSEQ_NEG_EXT7 : AUXSEQ_NEG_GROUND;
        end else begin
            // internal sources override the negative bit
            next_step_cfg.neg = AUXSEQ_NEG_AUTO;
            case (pos)
                4'h8:    next_step_cfg.src = AUXSEQ_SRC_TEMP;
                4'h9:    next_step_cfg.src = AUXSEQ_SRC_SHORT;
                4'ha:    next_step_cfg.src = AUXSEQ_SRC_TEST_DAC;
                default: next_step_cfg.src = AUXSEQ_SRC_SUPPLY;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            // decode of the reset word, spelled out as constants
            step_cfg <= '{step_active_flag: rst_word[`AUXSEQ_EN_BIT],
                          gain:             AUXSEQ_GAIN_1,
                          neg:              AUXSEQ_NEG_AUTO,
                          src:              AUXSEQ_SRC_SHORT,
                          pos_code:         rst_pos};
        end else begin
            step_cfg <= next_step_cfg;
        end
    end

    // decode checks look one edge back, the lag of the output flops

    chk_reserved_zero: assert property (
        @(posedge ref_clk) disable iff (reset)
        (ninth_step_setup & ~wr_mask) == '0
    ) else begin
        $error("reserved bits set");
    end

    chk_read_reserved: assert property (
        @(posedge ref_clk) disable iff (reset)
        rd_setup
        |=> prdata[31:16] == '0 && (prdata[15:0] & ~wr_mask) == '0
    ) else begin
        $error("reserved read bits set");
    end

    chk_write_lands: assert property (
        @(posedge ref_clk) disable iff (reset)
        wr_hit && pstrb[1:0] == 2'h3
        |=> ninth_step_setup == ($past(pwdata[15:0]) & wr_mask)
    ) else begin
        $error("write not stored");
    end

    chk_low_lane: assert property (
        @(posedge ref_clk) disable iff (reset)
        wr_hit && pstrb[1:0] == 2'h1
        |=> ninth_step_setup == {$past(ninth_step_setup[15:8]),
                                 $past(pwdata[7:0]) & wr_mask[7:0]}
    ) else begin
        $error("low lane write wrong");
    end

    chk_high_lane: assert property (
        @(posedge ref_clk) disable iff (reset)
        wr_hit && pstrb[1:0] == 2'h2
        |=> ninth_step_setup == {$past(pwdata[15:8]) & wr_mask[15:8],
                                 $past(ninth_step_setup[7:0])}
    ) else begin
        $error("high lane write wrong");
    end

    chk_idle_hold: assert property (
        @(posedge ref_clk) disable iff (reset)
        !wr_hit || pstrb[1:0] == 2'h0
        |=> $stable(ninth_step_setup)
    ) else begin
        $error("register changed without write");
    end

    chk_enable_follows: assert property (
        @(posedge ref_clk) disable iff (reset)
        ##1 step_cfg.step_active_flag ==
            $past(ninth_step_setup[`AUXSEQ_EN_BIT])
    ) else begin
        $error("enable not decoded");
    end

    chk_gain_one: assert property (
        @(posedge ref_clk) disable iff (reset)
        ninth_step_setup[`AUXSEQ_GAIN_HI:`AUXSEQ_GAIN_LO] == 2'h0
        |=> step_cfg.gain == AUXSEQ_GAIN_1
    ) else begin
        $error("gain 1 wrong");
    end

    chk_gain_two: assert property (
        @(posedge ref_clk) disable iff (reset)
        ninth_step_setup[`AUXSEQ_GAIN_HI:`AUXSEQ_GAIN_LO] == 2'h1
        |=> step_cfg.gain == AUXSEQ_GAIN_2
    ) else begin
        $error("gain 2 wrong");
    end

    chk_gain_four: assert property (
        @(posedge ref_clk) disable iff (reset)
        ninth_step_setup[`AUXSEQ_GAIN_HI]
        |=> step_cfg.gain == AUXSEQ_GAIN_4
    ) else begin
        $error("gain 4 wrong");
    end

    chk_neg_ground: assert property (
        @(posedge ref_clk) disable iff (reset)
        !ninth_step_setup[`AUXSEQ_POS_HI] &&
        !ninth_step_setup[`AUXSEQ_NEG_BIT]
        |=> step_cfg.neg == AUXSEQ_NEG_GROUND
    ) else begin
        $error("neg ground wrong");
    end

    chk_neg_ext: assert property (
        @(posedge ref_clk) disable iff (reset)
        !ninth_step_setup[`AUXSEQ_POS_HI] &&
        ninth_step_setup[`AUXSEQ_NEG_BIT]
        |=> step_cfg.neg == AUXSEQ_NEG_EXT7
    ) else begin
        $error("neg ext wrong");
    end

    chk_external_src: assert property (
        @(posedge ref_clk) disable iff (reset)
        !ninth_step_setup[`AUXSEQ_POS_HI]
        |=> step_cfg.src == AUXSEQ_SRC_EXTERNAL
    ) else begin
        $error("external source wrong");
    end

    chk_pos_code: assert property (
        @(posedge ref_clk) disable iff (reset)
        ##1 step_cfg.pos_code == $past(pos)
    ) else begin
        $error("positive code wrong");
    end

    chk_temp_src: assert property (
        @(posedge ref_clk) disable iff (reset)
        pos == `AUXSEQ_POS_FIRST_INT
        |=> step_cfg.src == AUXSEQ_SRC_TEMP
    ) else begin
        $error("temp source wrong");
    end

    chk_short_src: assert property (
        @(posedge ref_clk) disable iff (reset)
        pos == 4'h9
        |=> step_cfg.src == AUXSEQ_SRC_SHORT
    ) else begin
        $error("short source wrong");
    end

    chk_dac_src: assert property (
        @(posedge ref_clk) disable iff (reset)
        pos == 4'ha
        |=> step_cfg.src == AUXSEQ_SRC_TEST_DAC
    ) else begin
        $error("dac source wrong");
    end

    chk_supply_src: assert property (
        @(posedge ref_clk) disable iff (reset)
        pos > 4'ha
        |=> step_cfg.src == AUXSEQ_SRC_SUPPLY
    ) else begin
        $error("supply source wrong");
    end

    chk_internal_auto: assert property (
        @(posedge ref_clk) disable iff (reset)
        ninth_step_setup[`AUXSEQ_POS_HI]
        |=> step_cfg.neg == AUXSEQ_NEG_AUTO
    ) else begin
        $error("auto neg wrong");
    end

    chk_read_data: assert property (
        @(posedge ref_clk) disable iff (reset)
        rd_setup && hit
        |=> prdata == {16'h0000, $past(ninth_step_setup)}
    ) else begin
        $error("read data wrong");
    end

    chk_read_unmapped: assert property (
        @(posedge ref_clk) disable iff (reset)
        rd_setup && !hit
        |=> prdata == '0
    ) else begin
        $error("unmapped read not zero");
    end

    chk_read_hold: assert property (
        @(posedge ref_clk) disable iff (reset)
        !rd_setup
        |=> $stable(prdata)
    ) else begin
        $error("read data moved");
    end

    chk_reset_decode: assert property (
        @(posedge ref_clk) disable iff (reset)
        $fell(reset)
        |-> ninth_step_setup == rst_word &&
            step_cfg.pos_code == rst_pos &&
            !step_cfg.step_active_flag
    ) else begin
        $error("reset state wrong");
    end

    cov_enable: cover property (@(posedge ref_clk) disable iff (reset)
        step_cfg.step_active_flag);

    cov_temp: cover property (@(posedge ref_clk) disable iff (reset)
        step_cfg.src == AUXSEQ_SRC_TEMP);

    cov_bad_addr: cover property (@(posedge ref_clk) disable iff (reset)
        pslverr);

    cov_neg_ignored: cover property (@(posedge ref_clk) disable iff (reset)
        pos[`AUXSEQ_POS_HI] && ninth_step_setup[`AUXSEQ_NEG_BIT]);

    cov_low_lane: cover property (@(posedge ref_clk) disable iff (reset)
        wr_hit && pstrb[1:0] == 2'h1);

endmodule : auxseq_step9

/* File: testbench/auxseq_step9_tb.sv */
`timescale 1ns/1ps
`include "auxseq_defines.svh"
module auxseq_step9_tb
    import auxseq_pkg::*;
;
    logic             ref_clk = 0;
    logic             reset = 1;
    logic             psel = 0, penable = 0, pwrite = 0;
    logic [11:0]      paddr = 0;
    logic [31:0]      pwdata = 0, prdata, rd;
    logic [3:0]       pstrb = 0;
    logic             pready, pslverr, er;
    auxseq_step_cfg_t step_cfg;
    logic [15:0]      model;
    int               error_cnt = 0, samples_checked = 0;
    integer           seed = 32'h22fd;
    logic [31:0]      d;

    auxseq_step9 u_auxseq_step9 (.ref_clk(ref_clk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .step_cfg(step_cfg));

    always #2 ref_clk = ~ref_clk;

    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, input logic [3:0] s);
        int n = 0;
        @(posedge ref_clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
        pstrb <= w ? s : 4'h0;
        @(posedge ref_clk);
        penable <= 1;
        do begin @(posedge ref_clk); n++; end
        while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            error_cnt++;
            results();
        end
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb

    function automatic auxseq_step_cfg_t exp_cfg(input logic [15:0] r);
        auxseq_step_cfg_t c;
        c.step_active_flag = r[15];
        c.gain = r[14] ? AUXSEQ_GAIN_4 : r[13] ? AUXSEQ_GAIN_2
                                               : AUXSEQ_GAIN_1;
        c.neg = r[3] ? AUXSEQ_NEG_AUTO : r[4] ? AUXSEQ_NEG_EXT7
                                              : AUXSEQ_NEG_GROUND;
        c.src = !r[3] ? AUXSEQ_SRC_EXTERNAL :
                r[2:0] == 3'h0 ? AUXSEQ_SRC_TEMP :
                r[2:0] == 3'h1 ? AUXSEQ_SRC_SHORT :
                r[2:0] == 3'h2 ? AUXSEQ_SRC_TEST_DAC : AUXSEQ_SRC_SUPPLY;
        c.pos_code = r[3:0];
        return c;
    endfunction : exp_cfg

    task automatic cmp_word(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : cmp_word

    task automatic cmp_cfg(input auxseq_step_cfg_t e, g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD step_cfg exp %h got %h", e, g);
        end
    endtask : cmp_cfg

    // decode lags the register by a cycle, so let two edges pass
    task automatic check_all();
        repeat (2) @(posedge ref_clk);
        cmp_cfg(exp_cfg(model), step_cfg);
        apb(0, `AUXSEQ_ADDR_STEP9, 32'h0, 4'h0);
        cmp_word("readback", {16'h0, model}, rd);
        cmp_word("pslverr", 32'h0, {31'h0, er});
    endtask : check_all

    task automatic wr(input logic [31:0] wd, input logic [3:0] s);
        apb(1, `AUXSEQ_ADDR_STEP9, wd, s);
        if (s[0]) model[7:0] = wd[7:0];
        if (s[1]) model[15:8] = wd[15:8];
        model &= 16'he01f;
    endtask : wr

    initial begin
        repeat (10) @(posedge ref_clk);
        reset <= 0;
        model = 16'h0009;
        check_all();
        $display("test reset done");
        // reserved bits all set to show they never stick
        for (int i = 0; i < 16; i++) begin
            d = {16'hffff, i[1], i[1:0], 8'hff, ~i[0], i[3:0]};
            wr(d, 4'hf);
            check_all();
        end
        $display("test sweep done");
        for (int i = 0; i < 30; i++) begin
            d = $random(seed);
            wr(d, d[19:16]);
            check_all();
        end
        $display("test random done");
        apb(1, 12'h268, 32'hffffffff, 4'hf);
        cmp_word("pslverr", 32'h1, {31'h0, er});
        apb(0, 12'h268, 32'h0, 4'h0);
        cmp_word("unmapped", 32'h0, rd);
        check_all();
        $display("test unmapped done");
        @(posedge ref_clk);
        reset <= 1;
        repeat (2) @(posedge ref_clk);
        reset <= 0;
        model = 16'h0009;
        check_all();
        $display("test rereset done");
        results();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        results();
    end
endmodule : auxseq_step9_tb
